/* File: src/icx_cfg.v */
/*
 * Channel-number extension and transmit replay-buffer settings, reached
 * over an Avalon-MM slave with waitrequest, plus the channel and sequence
 * packing of burst control words that follows from those settings.
 * Assumes one clock and a synchronous active-high reset; the register
 * master and control word sources are synchronous to I_CLK.
 */
// Notes on behaviour
// - TX channel width select 0..3 gives 256..2048 channels at word bits 39:32..39:29.
// - RX decodes channel from bits 39:32..39:29 per its width select, default 0.
// - Replay buffer RAM is four equal banks; bank count picks those used.
// - Bank count 0,1,2,3 enables banks 0, 0-1, 0-2, all; default 3.
// - Multiplier codes 0..5 give x1..x32; codes 6 and 7 reserved; default 0.
// - TX multiplier here must equal link partner's RX multiplier.
// - Sequence number and channel extension share the multiple-use byte.
// - 14-bit replay depth, default 0x0800, bounds stored buffer entries.
// - One entry is one buffer write of eight words.
// - One word is 64 bits, eight bytes.
`timescale 1ns/1ps
`include "icx_cfg_defs.vh"

module icx_cfg #(
  parameter BANK_ENTRIES = 2048
) (
  // Clock and reset
  input  wire        I_CLK,
  input  wire        I_SYS_RST,
  // Avalon-MM slave
  input  wire [3:0]  I_AVS_ADDRESS,
  input  wire        I_AVS_READ,
  input  wire        I_AVS_WRITE,
  input  wire [31:0] I_AVS_WRITEDATA,
  input  wire [3:0]  I_AVS_BYTEENABLE,
  output reg  [31:0] O_AVS_READDATA,
  output reg         O_AVS_WAITREQUEST,
  // TX control word packing
  input  wire [63:0] I_TX_CTRL_WORD,
  input  wire [10:0] I_TX_CHANNEL,
  input  wire [7:0]  I_TX_SEQ,
  output reg  [63:0] O_TX_CTRL_WORD,
  // RX control word decoding
  input  wire [63:0] I_RX_CTRL_WORD,
  output reg  [10:0] O_RX_CHANNEL,
  output reg  [7:0]  O_RX_SEQ,
  // Replay buffer and channel width settings
  output reg  [3:0]  O_TX_BANK_ENABLE,
  output reg  [5:0]  O_TX_MULT_FACTOR,
  output reg  [13:0] O_TX_REPLAY_DEPTH,
  output reg  [16:0] O_TX_REPLAY_WORDS,
  output reg  [19:0] O_TX_REPLAY_BYTES,
  output reg  [1:0]  O_TX_CHANNEL_WIDTH_SELECT,
  output reg  [1:0]  O_RX_CHANNEL_WIDTH_SELECT
);

  reg  [1:0]  tx_channel_width_select;
  reg  [1:0]  rx_channel_width_select;
  reg  [1:0]  tx_replay_bank_count;
  reg  [2:0]  tx_sequence_multiplier;
  reg  [13:0] tx_replay_depth;

  reg  [31:0] next_readdata;
  reg  [5:0]  next_factor;
  reg  [1:0]  ext_limit;
  reg  [14:0] bank_cap;
  reg  [13:0] eff_depth;
  wire [31:0] be_mask;
  wire [3:0]  bank_en;
  wire [31:0] reg_chan;
  wire [31:0] reg_replay;
  wire [31:0] reg_depth;
  wire [31:0] reg_status;
  wire [31:0] wr_chan;
  wire [31:0] wr_replay;
  wire [31:0] wr_depth;
  wire        req;
  wire        wr_take;
  wire        mult_rsvd;
  wire        tx_wide;
  wire        rx_wide;
  wire [3:0]  seq_bits;
  wire [7:0]  tx_mu_mask;
  wire [7:0]  rx_mu_mask;
  wire [10:0] tx_chan_al;
  wire [10:0] rx_chan_al;

  // Byte lane mask and per-bank enables
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      assign be_mask[8*g+7:8*g] = {8{I_AVS_BYTEENABLE[g]}};
      assign bank_en[g]         = (g <= tx_replay_bank_count);
    end
  endgenerate

  assign req     = I_AVS_READ | I_AVS_WRITE;
  assign wr_take = I_AVS_WRITE & ~O_AVS_WAITREQUEST;

  assign reg_chan   = {28'h0000000, rx_channel_width_select, tx_channel_width_select};
  assign reg_replay = {25'h0000000, tx_sequence_multiplier, 2'h0, tx_replay_bank_count};
  assign reg_depth  = {18'h00000, tx_replay_depth};
  assign reg_status = {2'h0, eff_depth, 4'h0, seq_bits, bank_en,
                       1'h0, rx_wide, tx_wide, mult_rsvd};

  assign wr_chan   = (reg_chan & ~be_mask) | (I_AVS_WRITEDATA & be_mask);
  assign wr_replay = (reg_replay & ~be_mask) | (I_AVS_WRITEDATA & be_mask);
  assign wr_depth  = (reg_depth & ~be_mask) | (I_AVS_WRITEDATA & be_mask);

  // Settings registers
  always @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      tx_channel_width_select <= `ICX_RST_WSEL;
      rx_channel_width_select <= `ICX_RST_WSEL;
      tx_replay_bank_count    <= `ICX_RST_BANKS;
      tx_sequence_multiplier  <= `ICX_RST_MULT;
      tx_replay_depth         <= `ICX_RST_DEPTH;
    end else if (wr_take) begin
      case (I_AVS_ADDRESS)
        `ICX_OFS_CHAN: begin
          tx_channel_width_select <= wr_chan[`ICX_TX_WSEL_LSB+1:`ICX_TX_WSEL_LSB];
          rx_channel_width_select <= wr_chan[`ICX_RX_WSEL_LSB+1:`ICX_RX_WSEL_LSB];
        end
        `ICX_OFS_REPLAY: begin
          tx_replay_bank_count   <= wr_replay[`ICX_BANKS_LSB+1:`ICX_BANKS_LSB];
          tx_sequence_multiplier <= wr_replay[`ICX_MULT_LSB+2:`ICX_MULT_LSB];
        end
        `ICX_OFS_DEPTH: begin
          tx_replay_depth <= wr_depth[`ICX_DEPTH_LSB+13:`ICX_DEPTH_LSB];
        end
        default: begin
        end
      endcase
    end
  end

  // Multiplier factor; reserved codes give zero
  always @* begin
    case (tx_sequence_multiplier)
      3'h0:    next_factor = 6'h01;
      3'h1:    next_factor = 6'h02;
      3'h2:    next_factor = 6'h04;
      3'h3:    next_factor = 6'h08;
      3'h4:    next_factor = 6'h10;
      3'h5:    next_factor = 6'h20;
      default: next_factor = 6'h00;
    endcase
  end
  assign mult_rsvd = (tx_sequence_multiplier > `ICX_MULT_X32);

  // Widest channel field that leaves enough sequence bits
  always @* begin
    if (tx_sequence_multiplier <= `ICX_MULT_X4 || mult_rsvd) begin
      ext_limit = 2'h0;
    end else begin
      ext_limit = tx_sequence_multiplier[1:0] - 2'h2;
    end
  end
  assign tx_wide = (tx_channel_width_select > ext_limit);
  assign rx_wide = (rx_channel_width_select > ext_limit);

  // Sequence bits left in the multiple-use byte
  assign seq_bits = `ICX_MU_BITS - {2'h0, tx_channel_width_select};

  // Depth clamped to the capacity of the banks in use
  always @* begin
    bank_cap = BANK_ENTRIES[14:0] * ({13'h0000, tx_replay_bank_count} + 15'h0001);
    if ({1'h0, tx_replay_depth} > bank_cap) begin
      eff_depth = bank_cap[13:0];
    end else begin
      eff_depth = tx_replay_depth;
    end
  end

  // Channel fields left-justified at bit 39, sequence right-justified at bit 24
  assign tx_mu_mask = `ICX_MU_FULL >> tx_channel_width_select;
  assign rx_mu_mask = `ICX_MU_FULL >> rx_channel_width_select;
  assign tx_chan_al = I_TX_CHANNEL << (`ICX_EXT_MAX - tx_channel_width_select);
  assign rx_chan_al = I_RX_CTRL_WORD[`ICX_CW_CHAN_MSB:`ICX_CW_MU_MSB-2];

  // Register read mux
  always @* begin
    case (I_AVS_ADDRESS)
      `ICX_OFS_CHAN:   next_readdata = reg_chan;
      `ICX_OFS_REPLAY: next_readdata = reg_replay;
      `ICX_OFS_DEPTH:  next_readdata = reg_depth;
      `ICX_OFS_STATUS: next_readdata = reg_status;
      default:         next_readdata = 32'h00000000;
    endcase
  end

  // Bus handshake: one wait cycle, then a single-cycle acknowledge
  always @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_AVS_WAITREQUEST <= 1'h1;
      O_AVS_READDATA    <= 32'h00000000;
    end else begin
      O_AVS_WAITREQUEST <= ~(req & O_AVS_WAITREQUEST);
      if (I_AVS_READ & O_AVS_WAITREQUEST) begin
        O_AVS_READDATA <= next_readdata;
      end
    end
  end

  // Registered outputs
  always @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_TX_CTRL_WORD            <= 64'h0000000000000000;
      O_RX_CHANNEL              <= 11'h000;
      O_RX_SEQ                  <= 8'h00;
      O_TX_BANK_ENABLE          <= `ICX_RST_BANK_EN;
      O_TX_MULT_FACTOR          <= `ICX_RST_FACTOR;
      O_TX_REPLAY_DEPTH         <= `ICX_RST_DEPTH;
      O_TX_REPLAY_WORDS         <= {3'h0, `ICX_RST_DEPTH} << `ICX_ENTRY_SHIFT;
      O_TX_REPLAY_BYTES         <= {6'h00, `ICX_RST_DEPTH} << (`ICX_ENTRY_SHIFT
                                   + `ICX_WORD_BYTE_SHIFT);
      O_TX_CHANNEL_WIDTH_SELECT <= `ICX_RST_WSEL;
      O_RX_CHANNEL_WIDTH_SELECT <= `ICX_RST_WSEL;
    end else begin
      O_TX_CTRL_WORD[63:`ICX_CW_CHAN_MSB+1] <= I_TX_CTRL_WORD[63:`ICX_CW_CHAN_MSB+1];
      O_TX_CTRL_WORD[`ICX_CW_CHAN_MSB:`ICX_CW_CHAN_LSB] <= tx_chan_al[10:3];
      O_TX_CTRL_WORD[`ICX_CW_MU_MSB:`ICX_CW_MU_LSB] <=
        ({tx_chan_al[2:0], 5'h00} & ~tx_mu_mask) | (I_TX_SEQ & tx_mu_mask);
      O_TX_CTRL_WORD[`ICX_CW_MU_LSB-1:0] <= I_TX_CTRL_WORD[`ICX_CW_MU_LSB-1:0];
      O_RX_CHANNEL <= rx_chan_al >> (`ICX_EXT_MAX - rx_channel_width_select);
      O_RX_SEQ     <= I_RX_CTRL_WORD[`ICX_CW_MU_MSB:`ICX_CW_MU_LSB] & rx_mu_mask;
      O_TX_BANK_ENABLE  <= bank_en;
      O_TX_MULT_FACTOR  <= next_factor;
      O_TX_REPLAY_DEPTH <= eff_depth;
      O_TX_REPLAY_WORDS <= {3'h0, eff_depth} << `ICX_ENTRY_SHIFT;
      O_TX_REPLAY_BYTES <= {6'h00, eff_depth} << (`ICX_ENTRY_SHIFT
                           + `ICX_WORD_BYTE_SHIFT);
      O_TX_CHANNEL_WIDTH_SELECT <= tx_channel_width_select;
      O_RX_CHANNEL_WIDTH_SELECT <= rx_channel_width_select;
    end
  end

endmodule // icx_cfg

/* File: src/icx_cfg_defs.vh */
/*
 * Constants for the channel-extension and replay-buffer settings block:
 * register offsets, field positions, reset values and burst control word
 * field positions. Assumes it is included once per design file.
 */
`ifndef ICX_CFG_DEFS_VH
`define ICX_CFG_DEFS_VH

// Register byte offsets
`define ICX_OFS_CHAN          4'h0
`define ICX_OFS_REPLAY        4'h4
`define ICX_OFS_DEPTH         4'h8
`define ICX_OFS_STATUS        4'hc

// Channel register fields
`define ICX_TX_WSEL_LSB       0
`define ICX_RX_WSEL_LSB       2
// Replay register fields
`define ICX_BANKS_LSB         0
`define ICX_MULT_LSB          4
// Depth register field
`define ICX_DEPTH_LSB         0
// Status register fields
`define ICX_ST_MULT_RSVD      0
`define ICX_ST_TX_WIDE        1
`define ICX_ST_RX_WIDE        2
`define ICX_ST_BANK_LSB       4
`define ICX_ST_SEQ_LSB        8
`define ICX_ST_DEPTH_LSB      16

// Reset values
`define ICX_RST_WSEL          2'h0
`define ICX_RST_BANKS         2'h3
`define ICX_RST_MULT          3'h0
`define ICX_RST_DEPTH         14'h0800
`define ICX_RST_BANK_EN       4'hf
`define ICX_RST_FACTOR        6'h01

// Multiplier codes
`define ICX_MULT_X4           3'h2
`define ICX_MULT_X32          3'h5

// Burst control word: base channel byte and multiple-use byte
`define ICX_CW_CHAN_MSB       39
`define ICX_CW_CHAN_LSB       32
`define ICX_CW_MU_MSB         31
`define ICX_CW_MU_LSB         24
`define ICX_MU_FULL           8'hff
`define ICX_MU_BITS           4'h8
`define ICX_EXT_MAX           2'h3

// Entry and word sizing
`define ICX_ENTRY_SHIFT       3
`define ICX_WORD_BYTE_SHIFT   3

`endif

/* File: bench/icx_link_partner.sv */
/* Far-end model: builds RX burst control words at its own width select.
   Assumes its multiplier equals the device TX multiplier. */
`timescale 1ns/1ps
module icx_link_partner (
  // Clock and setting
  input  wire logic        i_clk,
  input  wire logic [1:0]  i_sel,
  // Burst fields
  input  wire logic [10:0] i_chan,
  input  wire logic [7:0]  i_seq,
  output logic      [63:0] o_word
);
  logic [15:0] mu;
  // Channel at the top of the shared field, sequence below it
  assign mu = ((16'(i_chan) & ((16'h100 << i_sel) - 16'h1)) << (8 - i_sel))
              | 16'(i_seq & (8'hff >> i_sel));
  always @(posedge i_clk) begin
    o_word <= {24'hc3a5f0, mu, 24'h0f5a3c};
  end
endmodule // icx_link_partner

/* File: bench/icx_cfg_properties.sv */
/* Port checker for icx_cfg. Assumes bind onto icx_cfg with BANK_ENTRIES. */
`timescale 1ns/1ps
module icx_cfg_properties #(parameter BANK_ENTRIES = 2048) (
  input wire logic        I_CLK,
  input wire logic        I_SYS_RST,
  input wire logic        I_AVS_READ,
  input wire logic        I_AVS_WRITE,
  input wire logic        O_AVS_WAITREQUEST,
  input wire logic [10:0] I_TX_CHANNEL,
  input wire logic [7:0]  I_TX_SEQ,
  input wire logic [63:0] O_TX_CTRL_WORD,
  input wire logic [63:0] I_RX_CTRL_WORD,
  input wire logic [10:0] O_RX_CHANNEL,
  input wire logic [7:0]  O_RX_SEQ,
  input wire logic [3:0]  O_TX_BANK_ENABLE,
  input wire logic [5:0]  O_TX_MULT_FACTOR,
  input wire logic [13:0] O_TX_REPLAY_DEPTH,
  input wire logic [16:0] O_TX_REPLAY_WORDS,
  input wire logic [19:0] O_TX_REPLAY_BYTES,
  input wire logic [1:0]  O_TX_CHANNEL_WIDTH_SELECT,
  input wire logic [1:0]  O_RX_CHANNEL_WIDTH_SELECT
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  wire [1:0] ts = O_TX_CHANNEL_WIDTH_SELECT;
  wire [1:0] rs = O_RX_CHANNEL_WIDTH_SELECT;
  sequence ack_s;
    !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST;
  endsequence
  bus_ack_a: assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> ack_s)
    else $error("bus answer timing wrong");
  // Outputs computed at a reset edge hold reset values, not packed fields
  tx_chan_a: assert property (!$past(I_SYS_RST) && $stable(ts) |->
    (O_TX_CTRL_WORD[39:29] >> (3 - ts)) ==
    ($past(I_TX_CHANNEL) & ((11'h100 << ts) - 1))) else $error("tx channel field wrong");
  tx_seq_a: assert property (!$past(I_SYS_RST) && $stable(ts) |->
    (O_TX_CTRL_WORD[31:24] & (8'hff >> ts)) ==
    ($past(I_TX_SEQ) & (8'hff >> ts))) else $error("tx sequence field wrong");
  rx_chan_a: assert property (!$past(I_SYS_RST) && $stable(rs) |->
    O_RX_CHANNEL ==
    (($past(I_RX_CTRL_WORD) >> (32 - rs)) & ((11'h100 << rs) - 1))) else $error("rx channel");
  rx_seq_a: assert property (!$past(I_SYS_RST) && $stable(rs) |->
    O_RX_SEQ ==
    (($past(I_RX_CTRL_WORD) >> 24) & (8'hff >> rs))) else $error("rx sequence wrong");
  bank_cap_a: assert property (O_TX_BANK_ENABLE[0] &&
    ((O_TX_BANK_ENABLE & (O_TX_BANK_ENABLE + 4'h1)) == 4'h0) &&
    (O_TX_REPLAY_DEPTH <= $countones(O_TX_BANK_ENABLE) * BANK_ENTRIES))
    else $error("bank enables or depth wrong");
  size_units_a: assert property (O_TX_REPLAY_WORDS == O_TX_REPLAY_DEPTH * 8 &&
    O_TX_REPLAY_BYTES == O_TX_REPLAY_WORDS * 8) else $error("replay size units wrong");
  mult_pow_a: assert property ($onehot0(O_TX_MULT_FACTOR))
    else $error("multiplier factor not a power of two");
endmodule // icx_cfg_properties
bind icx_cfg icx_cfg_properties #(.BANK_ENTRIES(BANK_ENTRIES)) u_props (.I_CLK, .I_SYS_RST,
  .I_AVS_READ, .I_AVS_WRITE, .O_AVS_WAITREQUEST, .I_TX_CHANNEL, .I_TX_SEQ, .O_TX_CTRL_WORD,
  .I_RX_CTRL_WORD, .O_RX_CHANNEL, .O_RX_SEQ, .O_TX_BANK_ENABLE, .O_TX_MULT_FACTOR,
  .O_TX_REPLAY_DEPTH, .O_TX_REPLAY_WORDS, .O_TX_REPLAY_BYTES, .O_TX_CHANNEL_WIDTH_SELECT,
  .O_RX_CHANNEL_WIDTH_SELECT);

/* File: bench/icx_cfg_tb.sv */
/* Bench for icx_cfg: Avalon-MM register access and control word packing.
   Assumes the partner model in icx_link_partner.sv. */
`timescale 1ns/1ps
module icx_cfg_tb;
  localparam int BE = 512;
  logic        clk = 0, rst = 1, rd = 0, wr = 0, wreq;
  logic [3:0]  addr = 4'h0, ben;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [63:0] txw = 64'h0, txo, rxw, exp;
  logic [10:0] chan = 11'h0, rxc;
  logic [7:0]  seq = 8'h0, rxs;
  logic [5:0]  fac;
  logic [13:0] dep;
  logic [16:0] wds;
  logic [19:0] byts;
  logic [1:0]  psel = 2'h0;
  int n_errors = 0, checks = 0;
  icx_cfg #(.BANK_ENTRIES(BE)) DUT (.I_CLK(clk), .I_SYS_RST(rst), .I_AVS_ADDRESS(addr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(4'hf),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq), .I_TX_CTRL_WORD(txw),
    .I_TX_CHANNEL(chan), .I_TX_SEQ(seq), .O_TX_CTRL_WORD(txo), .I_RX_CTRL_WORD(rxw),
    .O_RX_CHANNEL(rxc), .O_RX_SEQ(rxs), .O_TX_BANK_ENABLE(ben), .O_TX_MULT_FACTOR(fac),
    .O_TX_REPLAY_DEPTH(dep), .O_TX_REPLAY_WORDS(wds), .O_TX_REPLAY_BYTES(byts),
    .O_TX_CHANNEL_WIDTH_SELECT(), .O_RX_CHANNEL_WIDTH_SELECT());
  icx_link_partner u_partner (.i_clk(clk), .i_sel(psel), .i_chan(chan), .i_seq(seq),
    .o_word(rxw));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic close_out;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] want);
    checks++;
    if (got !== want) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 40) begin
      n_errors++;
      $display("unexpected at %0t: bus hang", $time);
      close_out;
    end
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd_reg(input logic [3:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_reg(4'h0);
    chk(q, 64'h0);
    rd_reg(4'h4);
    chk(q, 64'h3);
    rd_reg(4'h8);
    chk(q, 64'h800);
    chk(ben, 64'hf);
    chk(wds, 64'h4000);
    chk(byts, 64'h20000);
    // Unmapped address reads as zero
    rd_reg(4'h2);
    chk(q, 64'h0);
    for (int c = 0; c < 7; c++) begin
      wr_reg(4'h4, 32'h3 | (c << 4));
      settle;
      chk(fac, c < 6 ? 64'h1 << c : 64'h0);
    end
    // Reserved multiplier flagged; all banks; whole byte for sequence
    rd_reg(4'hc);
    chk(q, 64'h080008f1);
    wr_reg(4'h8, 32'h3fff);
    for (int b = 0; b < 4; b++) begin
      wr_reg(4'h4, 32'h50 | b);
      settle;
      chk(ben, (64'h2 << b) - 1);
      chk(dep, (b + 1) * BE);
      chk(byts, (b + 1) * BE * 64);
    end
    wr_reg(4'h8, 32'h123);
    settle;
    chk(dep, 64'h123);
    chk(wds, 64'h918);
    txw <= 64'h0123_4567_89ab_cdef;
    chan <= 11'h5a5;
    seq <= 8'hc3;
    for (int s = 0; s < 4; s++) begin
      psel <= s[1:0];
      wr_reg(4'h0, (s << 2) | s);
      settle;
      exp = txw;
      exp[39:24] = ((16'(chan) & ((16'h100 << s) - 1)) << (8 - s)) | (seq & (8'hff >> s));
      chk(txo, exp);
      chk(rxc, chan & ((11'h100 << s) - 1));
      chk(rxs, seq & (8'hff >> s));
      rd_reg(4'hc);
      chk(q, 64'h012300f0 | ((8 - s) << 8));
    end
    // x8 allows one extension bit: TX select 2 is flagged, RX select 1 is not
    wr_reg(4'h4, 32'h33);
    wr_reg(4'h0, 32'h6);
    rd_reg(4'hc);
    chk(q, 64'h012306f2);
    // Mid-run reset brings every setting back to its default
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_reg(4'h0);
    chk(q, 64'h0);
    rd_reg(4'h4);
    chk(q, 64'h3);
    rd_reg(4'hc);
    chk(q, 64'h080008f0);
    chk(fac, 64'h1);
    chk(dep, 64'h800);
    close_out;
  end
endmodule // icx_cfg_tb
